//--- include/pmc_pkg.sv
// constants and types for the counter array mode and pwm configuration block
package pmc_pkg;

  // special function register addresses
  localparam logic [7:0] PMC_MODE_ADDR = 8'hD9;
  localparam logic [7:0] PMC_PWM_ADDR = 8'hF7;
  // compare byte addresses for modules 0..2, shared with the reload bank
  localparam int PMC_NUM_MOD = 3;
  localparam logic [7:0] PMC_CMP_LO_ADDR [PMC_NUM_MOD] =
    '{8'hFB, 8'hE9, 8'hEB};
  localparam logic [7:0] PMC_CMP_HI_ADDR [PMC_NUM_MOD] =
    '{8'hFC, 8'hEA, 8'hEC};

  // mode register fields
  localparam int PMC_MD_IDLE_BIT = 7;
  localparam int PMC_MD_WDEN_BIT = 6;
  localparam int PMC_MD_LOCK_BIT = 5;
  localparam int PMC_MD_TBS_LSB = 1;
  localparam int PMC_MD_OVFIE_BIT = 0;
  localparam logic [7:0] PMC_MODE_RESET = 8'h40;

  // pwm configuration fields
  localparam int PMC_PW_BANK_BIT = 7;
  localparam int PMC_PW_COVIE_BIT = 6;
  localparam int PMC_PW_CYCLE_OVERFLOW_FLAG_BIT = 5;
  localparam int PMC_PW_WIDE_BIT = 3;
  localparam int PMC_PW_CLS_LSB = 0;
  localparam logic [7:0] PMC_PWM_RESET = 8'h00;
  localparam logic [15:0] PMC_RELOAD_RESET = 16'h0000;

  // timebase source codes
  typedef enum logic [2:0] {
    PMC_TB_DIV12 = 3'h0,
    PMC_TB_DIV4 = 3'h1,
    PMC_TB_T0OVF = 3'h2,
    PMC_TB_EXTPIN = 3'h3,
    PMC_TB_SYSCLK = 3'h4,
    PMC_TB_EXTDIV8 = 3'h5
  } pmc_tbs_e;

  // prescaler terminal counts
  localparam logic [3:0] PMC_DIV12_LAST = 4'hB;
  localparam logic [1:0] PMC_DIV4_LAST = 2'h3;
  localparam logic [2:0] PMC_EXT_DIV_LAST = 3'h7;

endpackage

//--- design/pmc_mode_ctrl.sv
// mode control, timebase select and reload bank for the counter array
`timescale 1ns/100ps
// Summary of operation
// - idle suspend halts counting during processor idle
// - watchdog enable hands module 2 to watchdog
// - lock makes watchdog enable uncleareable until reset
// - timebase field picks the counter increment source
// - external pin counts falling edges, quarter rate
// - external clock divided by eight, synchronised
// - overflow enable masks counter overflow request
// - watchdog enabled freezes mode bits other than enable and lock
// - mode bit four reads zero, ignores writes
// - bank select steers compare addresses to reload
// - reload values act only in pwm modes
// - cycle overflow enable gates cycle flag request
// - unlocked clear disables watchdog; enabled at reset
module pmc_mode_ctrl (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // special function register access
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // system status from the same clock domain
  input wire logic i_cpu_idle,
  input wire logic i_t0_overflow,
  input wire logic i_counter_overflow_flag,
  input wire logic i_cycle_overflow_flag,
  input wire logic [pmc_pkg::PMC_NUM_MOD-1:0] i_reload_mode_active,
  input wire logic [pmc_pkg::PMC_NUM_MOD-1:0] i_reload_event,
  // pins from outside the clock domain
  input wire logic i_external_count_input,
  input wire logic i_ext_osc,
  // controls toward the counter and modules
  output logic o_count_tick,
  output logic o_watchdog_enable,
  output logic o_watchdog_lock,
  output logic o_reload_bank_select,
  output logic o_wide_pwm_reload_enable,
  output logic [1:0] o_cycle_length_select,
  output logic o_overflow_irq_req,
  output logic o_cycle_irq_req,
  output logic [pmc_pkg::PMC_NUM_MOD-1:0] o_reload_load,
  output logic [16*pmc_pkg::PMC_NUM_MOD-1:0] o_reload_value
);
  import pmc_pkg::*;
  // mode register state
  logic idle_suspend_r, idle_suspend_nxt;
  logic watchdog_enable_r, watchdog_enable_nxt;
  logic watchdog_lock_r, watchdog_lock_nxt;
  logic [2:0] timebase_select_r, timebase_select_nxt;
  logic overflow_irq_enable_r, overflow_irq_enable_nxt;
  // pwm configuration state
  logic bank_r, bank_nxt;
  logic cyc_irq_enable_r, cyc_irq_enable_nxt;
  logic wide_r, wide_nxt;
  logic [1:0] cls_r, cls_nxt;
  // decoded writes
  logic mode_wr, pwm_wr;
  // read path and interrupt requests
  logic [7:0] rdata_r, rdata_nxt;
  logic ovf_irq_r, ovf_irq_nxt;
  logic cyc_irq_r, cyc_irq_nxt;
  // pin synchronisers; stage one feeds only stage two
  logic eci_s1_r, eci_s2_r, eci_s3_r;
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  // prescalers and tick
  logic [3:0] div12_r, div12_nxt;
  logic [1:0] div4_r, div4_nxt;
  logic [2:0] ext_div_r, ext_div_nxt;
  logic tick_r, tick_nxt;
  logic halted;
  // reload bank
  logic [15:0] reload_r [PMC_NUM_MOD];
  logic [PMC_NUM_MOD-1:0] load_r, load_nxt;
  // hit on any compare address, used for the read mux
  logic [PMC_NUM_MOD-1:0] lo_hit, hi_hit;
  assign mode_wr = i_sfr_wr && (i_sfr_addr == PMC_MODE_ADDR);
  assign pwm_wr = i_sfr_wr && (i_sfr_addr == PMC_PWM_ADDR);
  // mode register next state; watchdog bits handled apart from the rest
  always_comb begin
    idle_suspend_nxt = idle_suspend_r;
    watchdog_enable_nxt = watchdog_enable_r;
    watchdog_lock_nxt = watchdog_lock_r;
    timebase_select_nxt = timebase_select_r;
    overflow_irq_enable_nxt = overflow_irq_enable_r;
    if (mode_wr) begin
      // lock is sticky: only a system reset releases it
      watchdog_lock_nxt = watchdog_lock_r | i_sfr_wdata[PMC_MD_LOCK_BIT];
      watchdog_enable_nxt = watchdog_lock_nxt |
                            i_sfr_wdata[PMC_MD_WDEN_BIT];
      // the other fields move only while the watchdog is off
      if (!watchdog_enable_r) begin
        idle_suspend_nxt = i_sfr_wdata[PMC_MD_IDLE_BIT];
        timebase_select_nxt = i_sfr_wdata[PMC_MD_TBS_LSB +: 3];
        overflow_irq_enable_nxt = i_sfr_wdata[PMC_MD_OVFIE_BIT];
      end
    end
  end
  // mode register flops; watchdog comes up enabled
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle_suspend_r <= PMC_MODE_RESET[PMC_MD_IDLE_BIT];
      watchdog_enable_r <= PMC_MODE_RESET[PMC_MD_WDEN_BIT];
      watchdog_lock_r <= PMC_MODE_RESET[PMC_MD_LOCK_BIT];
      timebase_select_r <= PMC_MODE_RESET[PMC_MD_TBS_LSB +: 3];
      overflow_irq_enable_r <= PMC_MODE_RESET[PMC_MD_OVFIE_BIT];
    end else begin
      idle_suspend_r <= idle_suspend_nxt;
      watchdog_enable_r <= watchdog_enable_nxt;
      watchdog_lock_r <= watchdog_lock_nxt;
      timebase_select_r <= timebase_select_nxt;
      overflow_irq_enable_r <= overflow_irq_enable_nxt;
    end
  end
  // pwm configuration next state; cycle flag itself lives in the counter
  always_comb begin
    bank_nxt = bank_r;
    cyc_irq_enable_nxt = cyc_irq_enable_r;
    wide_nxt = wide_r;
    cls_nxt = cls_r;
    if (pwm_wr) begin
      bank_nxt = i_sfr_wdata[PMC_PW_BANK_BIT];
      cyc_irq_enable_nxt = i_sfr_wdata[PMC_PW_COVIE_BIT];
      wide_nxt = i_sfr_wdata[PMC_PW_WIDE_BIT];
      cls_nxt = i_sfr_wdata[PMC_PW_CLS_LSB +: 2];
    end
  end
  // pwm configuration flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bank_r <= PMC_PWM_RESET[PMC_PW_BANK_BIT];
      cyc_irq_enable_r <= PMC_PWM_RESET[PMC_PW_COVIE_BIT];
      wide_r <= PMC_PWM_RESET[PMC_PW_WIDE_BIT];
      cls_r <= PMC_PWM_RESET[PMC_PW_CLS_LSB +: 2];
    end else begin
      bank_r <= bank_nxt;
      cyc_irq_enable_r <= cyc_irq_enable_nxt;
      wide_r <= wide_nxt;
      cls_r <= cls_nxt;
    end
  end
  // reload bank, one 16-bit shadow per module
  generate
    for (genvar gm = 0; gm < PMC_NUM_MOD; gm++) begin : g_mod
      logic [15:0] rl_nxt;
      assign lo_hit[gm] = (i_sfr_addr == PMC_CMP_LO_ADDR[gm]);
      assign hi_hit[gm] = (i_sfr_addr == PMC_CMP_HI_ADDR[gm]);
      // writes reach the shadow only with the bank selected
      always_comb begin
        rl_nxt = reload_r[gm];
        if (i_sfr_wr && bank_r && lo_hit[gm]) begin
          rl_nxt[7:0] = i_sfr_wdata;
        end
        if (i_sfr_wr && bank_r && hi_hit[gm]) begin
          rl_nxt[15:8] = i_sfr_wdata;
        end
        // outside pwm modes the shadow must never reach the module
        load_nxt[gm] = i_reload_event[gm] & i_reload_mode_active[gm];
      end
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          reload_r[gm] <= PMC_RELOAD_RESET;
          load_r[gm] <= 1'b0;
        end else begin
          reload_r[gm] <= rl_nxt;
          load_r[gm] <= load_nxt[gm];
        end
      end
      assign o_reload_value[16*gm +: 16] = reload_r[gm];
    end
  endgenerate
  // read mux; compare addresses answer here only when the bank is selected
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_sfr_rd) begin
      if (i_sfr_addr == PMC_MODE_ADDR) begin
        rdata_nxt = {idle_suspend_r, watchdog_enable_r, watchdog_lock_r,
                     1'b0, timebase_select_r, overflow_irq_enable_r};
      end else if (i_sfr_addr == PMC_PWM_ADDR) begin
        rdata_nxt = {bank_r, cyc_irq_enable_r, i_cycle_overflow_flag,
                     1'b0, wide_r, 1'b0, cls_r};
      end else if (bank_r) begin
        for (int m = 0; m < PMC_NUM_MOD; m++) begin
          if (lo_hit[m]) begin
            rdata_nxt = reload_r[m][7:0];
          end
          if (hi_hit[m]) begin
            rdata_nxt = reload_r[m][15:8];
          end
        end
      end
    end
  end
  // interrupt request masks
  always_comb begin
    ovf_irq_nxt = overflow_irq_enable_r && i_counter_overflow_flag;
    cyc_irq_nxt = cyc_irq_enable_r && i_cycle_overflow_flag;
  end
  // read data and request flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_r <= 8'h00;
      ovf_irq_r <= 1'b0;
      cyc_irq_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ovf_irq_r <= ovf_irq_nxt;
      cyc_irq_r <= cyc_irq_nxt;
    end
  end
  // pin synchronisers; third stage only serves the edge detectors
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eci_s1_r <= 1'b1;
      eci_s2_r <= 1'b1;
      eci_s3_r <= 1'b1;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      eci_s1_r <= i_external_count_input;
      eci_s2_r <= eci_s1_r;
      eci_s3_r <= eci_s2_r;
      osc_s1_r <= i_ext_osc;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end
  // prescalers and increment source; everything freezes while suspended
  assign halted = idle_suspend_r && i_cpu_idle;
  always_comb begin
    div12_nxt = div12_r;
    div4_nxt = div4_r;
    ext_div_nxt = ext_div_r;
    tick_nxt = 1'b0;
    if (!halted) begin
      div12_nxt = (div12_r == PMC_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      div4_nxt = div4_r + 2'h1;
      // oscillator edges count even when another source is chosen
      if (osc_s2_r && !osc_s3_r) begin
        ext_div_nxt = ext_div_r + 3'h1;
      end
      case (timebase_select_r)
        PMC_TB_DIV12: tick_nxt = (div12_r == PMC_DIV12_LAST);
        PMC_TB_DIV4: tick_nxt = (div4_r == PMC_DIV4_LAST);
        PMC_TB_T0OVF: tick_nxt = i_t0_overflow;
        // pulses faster than a quarter of the clock may be missed
        PMC_TB_EXTPIN: tick_nxt = eci_s3_r && !eci_s2_r;
        PMC_TB_SYSCLK: tick_nxt = 1'b1;
        PMC_TB_EXTDIV8: tick_nxt = osc_s2_r && !osc_s3_r &&
                                   (ext_div_r == PMC_EXT_DIV_LAST);
        default: tick_nxt = 1'b0;
      endcase
    end
  end
  // prescaler and tick flops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div12_r <= 4'h0;
      div4_r <= 2'h0;
      ext_div_r <= 3'h0;
      tick_r <= 1'b0;
    end else begin
      div12_r <= div12_nxt;
      div4_r <= div4_nxt;
      ext_div_r <= ext_div_nxt;
      tick_r <= tick_nxt;
    end
  end
  // outputs straight from flops
  assign o_sfr_rdata = rdata_r;
  assign o_count_tick = tick_r;
  assign o_watchdog_enable = watchdog_enable_r;
  assign o_watchdog_lock = watchdog_lock_r;
  assign o_reload_bank_select = bank_r;
  assign o_wide_pwm_reload_enable = wide_r;
  assign o_cycle_length_select = cls_r;
  assign o_overflow_irq_req = ovf_irq_r;
  assign o_cycle_irq_req = cyc_irq_r;
  assign o_reload_load = load_r;
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_frozen_write;
    mode_wr && watchdog_enable_r;
  endsequence
  sequence s_div12_tick;
    o_count_tick && $past(timebase_select_r == PMC_TB_DIV12 && !halted);
  endsequence
  a_lock_forces_en: assert property (
    o_watchdog_lock |-> o_watchdog_enable)
    else $error("watchdog enable clear while locked");
  a_frozen_fields: assert property (
    s_frozen_write |=> $stable(timebase_select_r) && $stable(idle_suspend_r)
      && $stable(overflow_irq_enable_r))
    else $error("mode field changed while watchdog enabled");
  a_unlocked_clear: assert property (
    mode_wr && !watchdog_lock_r && i_sfr_wdata[6:5] == 2'b00
      |=> !o_watchdog_enable)
    else $error("unlocked clear left watchdog enabled");
  a_bit4_reads_zero: assert property (
    i_sfr_rd && i_sfr_addr == PMC_MODE_ADDR |=> o_sfr_rdata[4] == 1'b0)
    else $error("unused mode bit read as one");
  a_ovf_mask: assert property (
    o_overflow_irq_req == $past(overflow_irq_enable_r
      && i_counter_overflow_flag))
    else $error("overflow request does not follow mask");
  a_cyc_mask: assert property (
    o_cycle_irq_req |-> $past(cyc_irq_enable_r && i_cycle_overflow_flag))
    else $error("cycle request without enable and flag");
  a_div12_gap: assert property (
    s_div12_tick ##0 (timebase_select_r == PMC_TB_DIV12 && !halted)[*8]
      |-> !o_count_tick ##1 !o_count_tick)
    else $error("divide by twelve ticked too early");
  a_idle_halt: assert property (
    halted && $past(halted) |-> !o_count_tick)
    else $error("counter ticked while suspended");
  a_reserved_quiet: assert property (
    timebase_select_r[2:1] == 2'b11 && $past(timebase_select_r[2:1]) == 2'b11
      |-> !o_count_tick)
    else $error("reserved timebase produced a tick");
  a_reload_gate: assert property (
    (o_reload_load & ~$past(i_reload_mode_active)) == '0)
    else $error("reload outside pwm modes");
  a_bank_read: assert property (
    i_sfr_rd && bank_r && i_sfr_addr == PMC_CMP_LO_ADDR[0]
      |=> o_sfr_rdata == $past(reload_r[0][7:0]))
    else $error("bank read did not return reload byte");
  a_ext_edge: assert property (
    timebase_select_r == PMC_TB_EXTPIN && !halted && eci_s3_r && !eci_s2_r
      |=> o_count_tick)
    else $error("falling edge on count input missed");
endmodule

//--- bench/pmc_mode_ctrl_tb.sv
// self-checking bench for the counter array mode and pwm configuration block
`timescale 1ns/100ps
module pmc_mode_ctrl_tb;
  import pmc_pkg::*;
  // design inputs, all given a value at time zero
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_cpu_idle = 1'b0;
  logic i_t0_overflow = 1'b0;
  logic i_counter_overflow_flag = 1'b0;
  logic i_cycle_overflow_flag = 1'b0;
  logic [2:0] i_reload_mode_active = 3'h0;
  logic [2:0] i_reload_event = 3'h0;
  logic i_external_count_input = 1'b0;
  logic i_ext_osc = 1'b0;
  // design outputs
  logic [7:0] o_sfr_rdata;
  logic o_count_tick, o_watchdog_enable, o_watchdog_lock;
  logic o_reload_bank_select, o_wide_pwm_reload_enable;
  logic [1:0] o_cycle_length_select;
  logic o_overflow_irq_req, o_cycle_irq_req;
  logic [2:0] o_reload_load;
  logic [47:0] o_reload_value;
  // free-running pattern counters for the tick sources
  logic [2:0] gen_cnt = 3'h0;
  logic [2:0] t0_cnt = 3'h0;
  int n_fail = 0;
  int cmp_count = 0;
  // expected ticks in 96 cycles for each timebase code
  localparam int EXP_TICK [8] = '{8, 24, 16, 12, 96, 3, 0, 0};

  pmc_mode_ctrl uut (
    .i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_cpu_idle(i_cpu_idle), .i_t0_overflow(i_t0_overflow),
    .i_counter_overflow_flag(i_counter_overflow_flag),
    .i_cycle_overflow_flag(i_cycle_overflow_flag),
    .i_reload_mode_active(i_reload_mode_active),
    .i_reload_event(i_reload_event),
    .i_external_count_input(i_external_count_input),
    .i_ext_osc(i_ext_osc), .o_count_tick(o_count_tick),
    .o_watchdog_enable(o_watchdog_enable),
    .o_watchdog_lock(o_watchdog_lock),
    .o_reload_bank_select(o_reload_bank_select),
    .o_wide_pwm_reload_enable(o_wide_pwm_reload_enable),
    .o_cycle_length_select(o_cycle_length_select),
    .o_overflow_irq_req(o_overflow_irq_req),
    .o_cycle_irq_req(o_cycle_irq_req),
    .o_reload_load(o_reload_load), .o_reload_value(o_reload_value)
  );

  // 100 MHz system clock
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // pin and timer patterns: pin falls every 8 cycles, which keeps it
  // well under the quarter-rate limit; osc rises every 4; t0 every 6
  always @(posedge i_clk) begin
    gen_cnt <= gen_cnt + 3'h1;
    t0_cnt <= (t0_cnt == 3'h5) ? 3'h0 : t0_cnt + 3'h1;
    i_ext_osc <= gen_cnt[1];
    i_external_count_input <= gen_cnt[2];
    i_t0_overflow <= (t0_cnt == 3'h5);
  end

  // one comparison, counted, mismatch printed at once
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait one edge, then a one-cycle write strobe, dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_clk);
    i_sfr_wr <= 1'b0;
  endtask

  // read strobe; data stands for one cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(posedge i_clk);
    i_sfr_rd <= 1'b0;
    #1;
    chk(o_sfr_rdata, e);
  endtask

  // settle, then count increments over 96 cycles
  task automatic ticks(input int exp);
    int c;
    c = 0;
    repeat (8) @(posedge i_clk);
    repeat (96) begin
      @(posedge i_clk);
      #1;
      if (o_count_tick === 1'b1) c++;
    end
    chk(48'(c), 48'(exp));
  endtask

  // asynchronous reset held for four cycles
  task automatic do_reset();
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_arst_n <= 1'b1;
    #1;
  endtask

  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the roughly 1250 cycles the tests need
  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  initial begin
    do_reset();
    chk(o_watchdog_enable, 1'b1);
    rd(PMC_MODE_ADDR, PMC_MODE_RESET);
    rd(PMC_PWM_ADDR, PMC_PWM_RESET);
    rd(8'h00, 8'h00);
    rd(PMC_CMP_LO_ADDR[0], 8'h00);
    // watchdog on: only enable and lock may move
    wr(PMC_MODE_ADDR, 8'hCF);
    rd(PMC_MODE_ADDR, 8'h40);
    // clearing enable while unlocked turns the watchdog off
    wr(PMC_MODE_ADDR, 8'h9F);
    #1;
    chk(o_watchdog_enable, 1'b0);
    rd(PMC_MODE_ADDR, 8'h00);
    // bit four is dropped, overflow enable taken
    wr(PMC_MODE_ADDR, 8'h11);
    rd(PMC_MODE_ADDR, 8'h01);
    @(posedge i_clk) i_counter_overflow_flag <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(o_overflow_irq_req, 1'b1);
    wr(PMC_MODE_ADDR, 8'h00);
    // the request lags the mask by one registered cycle
    @(posedge i_clk) i_counter_overflow_flag <= 1'b0;
    #1;
    chk(o_overflow_irq_req, 1'b0);
    // every timebase code, reserved ones give no ticks
    for (int k = 0; k < 8; k++) begin
      wr(PMC_MODE_ADDR, 8'(k << 1));
      ticks(EXP_TICK[k]);
    end
    // idle suspend with system clock source
    wr(PMC_MODE_ADDR, 8'h88);
    i_cpu_idle <= 1'b1;
    ticks(0);
    @(posedge i_clk) i_cpu_idle <= 1'b0;
    ticks(96);
    wr(PMC_MODE_ADDR, 8'h08);
    i_cpu_idle <= 1'b1;
    ticks(96);
    @(posedge i_clk) i_cpu_idle <= 1'b0;
    // pwm configuration: bit four dropped, bit five mirrors the flag
    wr(PMC_PWM_ADDR, 8'hDB);
    rd(PMC_PWM_ADDR, 8'hCB);
    chk({o_reload_bank_select, o_wide_pwm_reload_enable,
         o_cycle_length_select}, 4'hF);
    @(posedge i_clk) i_cycle_overflow_flag <= 1'b1;
    rd(PMC_PWM_ADDR, 8'hEB);
    chk(o_cycle_irq_req, 1'b1);
    wr(PMC_PWM_ADDR, 8'h8B);
    @(posedge i_clk) i_cycle_overflow_flag <= 1'b0;
    #1;
    chk(o_cycle_irq_req, 1'b0);
    // reload bank reached through the compare byte addresses
    for (int m = 0; m < PMC_NUM_MOD; m++) begin
      wr(PMC_CMP_LO_ADDR[m], 8'(8'h10 + m));
      wr(PMC_CMP_HI_ADDR[m], 8'(8'hA0 + m));
    end
    for (int m = 0; m < PMC_NUM_MOD; m++) begin
      rd(PMC_CMP_LO_ADDR[m], 8'(8'h10 + m));
      rd(PMC_CMP_HI_ADDR[m], 8'(8'hA0 + m));
    end
    chk(o_reload_value, 48'hA212_A111_A010);
    // reload only in modules that are in a pwm reload mode
    @(posedge i_clk);
    i_reload_mode_active <= 3'h5;
    i_reload_event <= 3'h7;
    @(posedge i_clk) i_reload_event <= 3'h0;
    #1;
    chk(o_reload_load, 3'h5);
    @(posedge i_clk);
    #1;
    chk(o_reload_load, 3'h0);
    // bank cleared: compare writes leave the shadow alone
    wr(PMC_PWM_ADDR, 8'h00);
    wr(PMC_CMP_LO_ADDR[0], 8'h55);
    rd(PMC_CMP_LO_ADDR[0], 8'h00);
    chk(o_reload_value, 48'hA212_A111_A010);
    // lock sets enable and blocks its clearing until reset
    wr(PMC_MODE_ADDR, 8'h20);
    #1;
    chk({o_watchdog_enable, o_watchdog_lock}, 2'h3);
    wr(PMC_MODE_ADDR, 8'h00);
    rd(PMC_MODE_ADDR, 8'h60);
    // a second reset frees the lock and re-enables the watchdog
    do_reset();
    chk({o_watchdog_enable, o_watchdog_lock}, 2'h2);
    rd(PMC_MODE_ADDR, PMC_MODE_RESET);
    summarize();
  end
endmodule
